/* include/hbcfl_defs.vh */
// Constants shared by the full-bridge control and fault logic.
`ifndef HBCFL_DEFS_VH
`define HBCFL_DEFS_VH
// Clock rate in MHz.
`define HBCFL_CLK_MHZ 200
// Crossover dead time in ns, and its count of clock cycles (least time, rounded up).
`define HBCFL_DEAD_NS 500
`define HBCFL_DEAD_CYC ((`HBCFL_DEAD_NS * `HBCFL_CLK_MHZ + 999) / 1000)
// Overcurrent retry period in us, and its count of clock cycles.
`define HBCFL_RETRY_US 1200
`define HBCFL_RETRY_CYC (`HBCFL_RETRY_US * `HBCFL_CLK_MHZ)
// Bridge leg drive encoding: {high-side on, low-side on}.
`define HBCFL_LEG_OFF 2'h0
`define HBCFL_LEG_LOW 2'h1
`define HBCFL_LEG_HIGH 2'h2
// APB register byte offsets.
`define HBCFL_REG_CTRL 8'h00
`define HBCFL_REG_STAT 8'h04
`define HBCFL_REG_RETRY 8'h08
// Control register field positions and reset value.
`define HBCFL_CTRL_EN_BIT 0
`define HBCFL_CTRL_DIR_BIT 1
`define HBCFL_CTRL_DECAY_BIT 2
`define HBCFL_CTRL_SIDE_BIT 3
`define HBCFL_CTRL_WAKE_BIT 4
`define HBCFL_CTRL_SRC_BIT 5
`define HBCFL_CTRL_RESET 32'h00000000
`endif

/* logic/hbcfl_top.v */
// Control, protection and flag logic of a single full-bridge motor driver.
// Overview of operation
// - Standby low forces both outputs high impedance.
// - Decay select high is slow, low fast.
// - Side select picks high or low recirculation.
// - Enable high drives per direction select.
// - Enable low, slow, low side: brake.
// - Brake holds while enable stays low.
// - Fast decay switches opposite drivers on.
// - Fast decay floats outputs near zero current.
// - Dead time between leg driver changes.
// - Flag low on fault, undervoltage, warning.
// - Flag meaningless during standby.
// - Undervoltage flag holds until release level.
// - Flag never alters bridge behaviour itself.
// - Thermal warning flags, bridge keeps running.
// - Thermal cutoff disables until hysteresis cleared.
// - Short turns off bridge, flags, starts timer.
// - Timer expiry releases flag, retries turn-on.
// - No short after retry resumes normally.
// - Shunt trip forces recirculation.
// - Lockout and low pump rail disable outputs.
`include "hbcfl_defs.vh"
module hbcfl_top #(
   parameter RETRY_CYCLES = `HBCFL_RETRY_CYC,
   parameter DEAD_CYCLES = `HBCFL_DEAD_CYC
) (
   input wire SYS_CLK_IN,
   input wire RST_IN,
   input wire STANDBY_REQUEST_N_IN,
   input wire ENABLE_IN,
   input wire DIRECTION_SELECT_IN,
   input wire DECAY_SELECT_IN,
   input wire RECIRC_SIDE_SELECT_IN,
   input wire SHORT_DETECT_IN,
   input wire SHUNT_TRIP_IN,
   input wire CURRENT_NEAR_ZERO_IN,
   input wire SUPPLY_LOCKOUT_IN,
   input wire SUPPLY_BELOW_RELEASE_IN,
   input wire PUMP_RAIL_LOW_IN,
   input wire THERMAL_WARN_IN,
   input wire THERMAL_CUTOFF_IN,
   input wire PSEL_IN,
   input wire PENABLE_IN,
   input wire PWRITE_IN,
   input wire [7:0] PADDR_IN,
   input wire [31:0] PWDATA_IN,
   output wire PREADY_OUT,
   output reg [31:0] PRDATA_OUT,
   output wire PSLVERR_OUT,
   output wire POS_HIGH_ON_OUT,
   output wire POS_LOW_ON_OUT,
   output wire NEG_HIGH_ON_OUT,
   output wire NEG_LOW_ON_OUT,
   output wire RAILS_ENABLE_OUT,
   output wire PROBLEM_FLAG_N_OUT,
   output wire PROBLEM_FLAG_OE_OUT
);
   // Overcurrent sequencer states: normal running, timed shutdown, single retry cycle.
   localparam ST_RUN = 2'h0;
   localparam ST_FAULT = 2'h1;
   localparam ST_RETRY = 2'h2;
   localparam CW = 24;
   localparam DW = 8;
   // Terminal counts are worked out at full integer width and then cut to the counter widths.
   // A retry period beyond the 24-bit counter, or a dead time of more than 256 cycles, would wrap.
   localparam [31:0] RETRY_LAST_W = RETRY_CYCLES - 1;
   localparam [31:0] DEAD_LAST_W = DEAD_CYCLES - 1;
   localparam [CW-1:0] RETRY_LAST = RETRY_LAST_W[CW-1:0];
   localparam [DW-1:0] DEAD_LAST = DEAD_LAST_W[DW-1:0];

   reg [31:0] ctrl_r;
   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [CW-1:0] retry_cnt_r;
   reg [CW-1:0] retry_cnt_nxt;
   reg [15:0] retry_count_r;
   reg uv_hold_r;
   reg [1:0] want_pos;
   reg [1:0] want_neg;
   reg [1:0] pos_r;
   reg [1:0] neg_r;
   reg [DW-1:0] pos_dead_r;
   reg [DW-1:0] neg_dead_r;
   reg [1:0] pos_last_r;
   reg [1:0] neg_last_r;
   wire awake;
   wire en;
   wire dir;
   wire decay;
   wire side;
   wire bridge_off;
   wire flag_low;
   wire apb_wr;
   wire apb_rd;
   wire shut_event;

   // Command inputs come from pins or, when selected, from the control register.
   // The select is a plain mux, so a source change takes effect at once; software should
   // load the register commands before it flips the source bit.
   assign en = ctrl_r[`HBCFL_CTRL_SRC_BIT] ? ctrl_r[`HBCFL_CTRL_EN_BIT] : ENABLE_IN;
   assign dir = ctrl_r[`HBCFL_CTRL_SRC_BIT] ? ctrl_r[`HBCFL_CTRL_DIR_BIT] : DIRECTION_SELECT_IN;
   assign decay = ctrl_r[`HBCFL_CTRL_SRC_BIT] ? ctrl_r[`HBCFL_CTRL_DECAY_BIT] : DECAY_SELECT_IN;
   assign side = ctrl_r[`HBCFL_CTRL_SRC_BIT] ? ctrl_r[`HBCFL_CTRL_SIDE_BIT] : RECIRC_SIDE_SELECT_IN;
   // Software may hold the part in standby too; the pin always wins when low.
   assign awake = STANDBY_REQUEST_N_IN & ~(ctrl_r[`HBCFL_CTRL_SRC_BIT] & ~ctrl_r[`HBCFL_CTRL_WAKE_BIT]);
   assign RAILS_ENABLE_OUT = awake;

   // Every condition that takes the drivers off; the flag is deliberately absent here.
   assign bridge_off = ~awake | SUPPLY_LOCKOUT_IN | PUMP_RAIL_LOW_IN | THERMAL_CUTOFF_IN
      | (state_r == ST_FAULT);

   // APB slave: zero wait states, unmapped addresses read zero and report an error.
   // The slave never stretches a transfer, since every register answers from flops.
   // Writes to the status register are dropped without an error, as it is simply read-only.
   assign apb_wr = PSEL_IN & PENABLE_IN & PWRITE_IN;
   assign apb_rd = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
   assign PREADY_OUT = 1'b1;
   assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & (PADDR_IN != `HBCFL_REG_CTRL)
      & (PADDR_IN != `HBCFL_REG_STAT) & (PADDR_IN != `HBCFL_REG_RETRY);

   // Only the six defined control bits are stored; the rest read back as zero.
   always @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
         ctrl_r <= `HBCFL_CTRL_RESET;
      else if (apb_wr && PADDR_IN == `HBCFL_REG_CTRL)
         ctrl_r <= {26'h0000000, PWDATA_IN[5:0]};
   end

   // Read data is registered in the setup cycle so it stands during the access phase.
   always @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
         PRDATA_OUT <= 32'h00000000;
      else if (apb_rd)
      begin
         case (PADDR_IN)
            `HBCFL_REG_CTRL: PRDATA_OUT <= ctrl_r;
            `HBCFL_REG_STAT: PRDATA_OUT <= {20'h00000, pos_r, neg_r, ~flag_low, uv_hold_r,
               THERMAL_CUTOFF_IN, THERMAL_WARN_IN, state_r, awake, 1'b0};
            `HBCFL_REG_RETRY: PRDATA_OUT <= {16'h0000, retry_count_r};
            default: PRDATA_OUT <= 32'h00000000;
         endcase
      end
   end

   // Overcurrent sequencer: a short stops the bridge for the retry period, then retries.
   // The counter runs only in the fault state; in the retry cycle the bridge drives again
   // and the short detector alone decides whether the shutdown repeats.
   always @*
   begin
      state_nxt = state_r;
      retry_cnt_nxt = retry_cnt_r;
      case (state_r)
         ST_RUN:
         begin
            if (SHORT_DETECT_IN)
            begin
               state_nxt = ST_FAULT;
               retry_cnt_nxt = {CW{1'b0}};
            end
         end
         ST_FAULT:
         begin
            if (retry_cnt_r == RETRY_LAST)
               state_nxt = ST_RETRY;
            else
               retry_cnt_nxt = retry_cnt_r + 1'b1;
         end
         ST_RETRY:
         begin
            // One cycle of renewed drive decides whether the short is still there.
            if (SHORT_DETECT_IN)
            begin
               state_nxt = ST_FAULT;
               retry_cnt_nxt = {CW{1'b0}};
            end
            else
               state_nxt = ST_RUN;
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   // Sleep and reset both clear the timer, so a wake never inherits a stale fault.
   always @(posedge SYS_CLK_IN)
   begin
      if (RST_IN || !awake)
      begin
         state_r <= ST_RUN;
         retry_cnt_r <= {CW{1'b0}};
      end
      else
      begin
         state_r <= state_nxt;
         retry_cnt_r <= retry_cnt_nxt;
      end
   end

   // A shutdown starts whenever the sequencer enters the fault state while awake.
   assign shut_event = (state_r != ST_FAULT) & (state_nxt == ST_FAULT) & awake;

   // Count of shutdowns for software; it saturates rather than wraps.
   // A shutdown in the same cycle as a clearing write is kept, so no event is lost.
   always @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
         retry_count_r <= 16'h0000;
      else if (apb_wr && PADDR_IN == `HBCFL_REG_RETRY)
      begin
         if (shut_event)
            retry_count_r <= 16'h0001;
         else
            retry_count_r <= 16'h0000;
      end
      else if (shut_event && retry_count_r != 16'hFFFF)
         retry_count_r <= retry_count_r + 16'h0001;
   end

   // An undervoltage latches the flag until the supply passes the release level.
   // A new lockout in the same cycle as the release wins, so the flag never drops early.
   always @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
         uv_hold_r <= 1'b1;
      else if (SUPPLY_LOCKOUT_IN || PUMP_RAIL_LOW_IN)
         uv_hold_r <= 1'b1;
      else if (!SUPPLY_BELOW_RELEASE_IN)
         uv_hold_r <= 1'b0;
   end

   // Open-drain flag: enable high pulls the pin low. Sleep state is undefined to the host.
   // The pin is only ever pulled low or released, so several parts may share one pull-up.
   assign flag_low = (state_r == ST_FAULT) | uv_hold_r | SUPPLY_LOCKOUT_IN
      | THERMAL_WARN_IN | THERMAL_CUTOFF_IN;
   assign PROBLEM_FLAG_N_OUT = 1'b0;
   assign PROBLEM_FLAG_OE_OUT = flag_low;

   // Requested leg states from the command decode.
   // Priority runs from protection to drive to recirculation, so no command overrides a fault.
   // The shunt trip only drops the drive term, which leaves the winding in whichever
   // recirculation the decay inputs select.
   always @*
   begin
      want_pos = `HBCFL_LEG_OFF;
      want_neg = `HBCFL_LEG_OFF;
      if (bridge_off)
      begin
         want_pos = `HBCFL_LEG_OFF;
         want_neg = `HBCFL_LEG_OFF;
      end
      else if (en && !SHUNT_TRIP_IN)
      begin
         want_pos = dir ? `HBCFL_LEG_HIGH : `HBCFL_LEG_LOW;
         want_neg = dir ? `HBCFL_LEG_LOW : `HBCFL_LEG_HIGH;
      end
      else if (decay)
      begin
         // Slow decay holds as long as enable stays low, shorting the motor.
         want_pos = side ? `HBCFL_LEG_HIGH : `HBCFL_LEG_LOW;
         want_neg = side ? `HBCFL_LEG_HIGH : `HBCFL_LEG_LOW;
      end
      else if (!CURRENT_NEAR_ZERO_IN)
      begin
         want_pos = dir ? `HBCFL_LEG_LOW : `HBCFL_LEG_HIGH;
         want_neg = dir ? `HBCFL_LEG_HIGH : `HBCFL_LEG_LOW;
      end
      // Near zero current in fast decay both legs float, so the current cannot reverse.
   end

   // Each leg remembers the driver it last had on. Returning to that same driver after a
   // float needs no guard, since the opposite switch was never on in between; only a
   // change of side pays the dead time, which keeps the restart after a shutdown or short retry free of extra delay.

   // Positive leg: going off is immediate, a change to the other driver waits out the dead time.
   always @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
      begin
         pos_r <= `HBCFL_LEG_OFF;
         pos_last_r <= `HBCFL_LEG_OFF;
         pos_dead_r <= {DW{1'b0}};
      end
      else if (want_pos == `HBCFL_LEG_OFF || want_pos == pos_r)
      begin
         pos_r <= want_pos;
         if (pos_r != `HBCFL_LEG_OFF)
            pos_last_r <= pos_r;
         pos_dead_r <= {DW{1'b0}};
      end
      else if (pos_r != `HBCFL_LEG_OFF)
      begin
         pos_last_r <= pos_r;
         pos_r <= `HBCFL_LEG_OFF;
         pos_dead_r <= {DW{1'b0}};
      end
      else if (want_pos == pos_last_r || pos_dead_r == DEAD_LAST)
      begin
         pos_r <= want_pos;
         pos_last_r <= want_pos;
      end
      else
         pos_dead_r <= pos_dead_r + 1'b1;
   end

   // Negative leg: same crossover guard as the positive leg.
   always @(posedge SYS_CLK_IN)
   begin
      if (RST_IN)
      begin
         neg_r <= `HBCFL_LEG_OFF;
         neg_last_r <= `HBCFL_LEG_OFF;
         neg_dead_r <= {DW{1'b0}};
      end
      else if (want_neg == `HBCFL_LEG_OFF || want_neg == neg_r)
      begin
         neg_r <= want_neg;
         if (neg_r != `HBCFL_LEG_OFF)
            neg_last_r <= neg_r;
         neg_dead_r <= {DW{1'b0}};
      end
      else if (neg_r != `HBCFL_LEG_OFF)
      begin
         neg_last_r <= neg_r;
         neg_r <= `HBCFL_LEG_OFF;
         neg_dead_r <= {DW{1'b0}};
      end
      else if (want_neg == neg_last_r || neg_dead_r == DEAD_LAST)
      begin
         neg_r <= want_neg;
         neg_last_r <= want_neg;
      end
      else
         neg_dead_r <= neg_dead_r + 1'b1;
   end

   // Gate drives straight from the leg flops; both off means high impedance.
   // Being plain flop outputs, they carry no decode glitch to the bridge.
   // A leg code with both bits set is never produced, and the checker watches for it.
   assign POS_HIGH_ON_OUT = pos_r[1];
   assign POS_LOW_ON_OUT = pos_r[0];
   assign NEG_HIGH_ON_OUT = neg_r[1];
   assign NEG_LOW_ON_OUT = neg_r[0];
endmodule

/* tb/hbcfl_monitor.sv */
// Checker of leg, sleep and flag behaviour at the bridge ports.
module hbcfl_monitor #(
   parameter RETRY_CYCLES = 20,
   parameter DEAD_CYCLES = 4
) (
   input wire SYS_CLK_IN,
   input wire RST_IN,
   input wire STANDBY_REQUEST_N_IN,
   input wire SHORT_DETECT_IN,
   input wire THERMAL_WARN_IN,
   input wire THERMAL_CUTOFF_IN,
   input wire PUMP_RAIL_LOW_IN,
   input wire SUPPLY_LOCKOUT_IN,
   input wire POS_HIGH_ON_OUT,
   input wire POS_LOW_ON_OUT,
   input wire NEG_HIGH_ON_OUT,
   input wire NEG_LOW_ON_OUT,
   input wire RAILS_ENABLE_OUT,
   input wire PROBLEM_FLAG_OE_OUT
);
   timeunit 1ns;
   timeprecision 100ps;
   // Any driver on; the checks below want it off in every protective state.
   wire any_on = POS_HIGH_ON_OUT | POS_LOW_ON_OUT | NEG_HIGH_ON_OUT | NEG_LOW_ON_OUT;
   wire stop = THERMAL_CUTOFF_IN | PUMP_RAIL_LOW_IN | SUPPLY_LOCKOUT_IN;
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (RST_IN);
   property p_sleep; !STANDBY_REQUEST_N_IN [*3] |-> !any_on; endproperty
   a_sleep: assert property (p_sleep) else $error("legs on in sleep");
   property p_rails; !STANDBY_REQUEST_N_IN |-> !RAILS_ENABLE_OUT; endproperty
   a_rails: assert property (p_rails) else $error("rails on in sleep");
   property p_shoot; !(POS_HIGH_ON_OUT && POS_LOW_ON_OUT) && !(NEG_HIGH_ON_OUT && NEG_LOW_ON_OUT); endproperty
   a_shoot: assert property (p_shoot) else $error("both drivers on one leg");
   property p_dead; $rose(POS_LOW_ON_OUT) |-> !$past(POS_HIGH_ON_OUT) && !$past(POS_HIGH_ON_OUT, DEAD_CYCLES); endproperty
   a_dead: assert property (p_dead) else $error("no dead time");
   property p_warn; THERMAL_WARN_IN && STANDBY_REQUEST_N_IN |-> ##[0:2] PROBLEM_FLAG_OE_OUT; endproperty
   a_warn: assert property (p_warn) else $error("warning not flagged");
   property p_stop; stop [*3] |-> !any_on; endproperty
   a_stop: assert property (p_stop) else $error("legs on in shutdown");
   property p_short; $rose(SHORT_DETECT_IN) && STANDBY_REQUEST_N_IN |-> ##3 !any_on [*8]; endproperty
   a_short: assert property (p_short) else $error("legs on after short");
   property p_sflag; $rose(SHORT_DETECT_IN) && STANDBY_REQUEST_N_IN |-> ##[1:3] PROBLEM_FLAG_OE_OUT; endproperty
   a_sflag: assert property (p_sflag) else $error("short not flagged");
endmodule

/* tb/hbcfl_host_model.sv */
// Host controller model driving the wake and command pins.
module hbcfl_host_model #(
   parameter WAKE_CYCLES = 40
) (
   input wire clk_in,
   input wire wake_in,
   input wire [3:0] cmd_in,
   input wire flag_oe_in,
   output logic standby_n_out = 1'b0,
   output logic [3:0] cmd_out = 4'h0,
   output wire flag_seen_out
);
   timeunit 1ns;
   timeprecision 100ps;
   int settle_r = WAKE_CYCLES;
   // Enable is held low after wake so the pump settles before any drive.
   always @(posedge clk_in)
   begin
      standby_n_out <= wake_in;
      settle_r <= !wake_in ? WAKE_CYCLES : (settle_r > 0 ? settle_r - 1 : 0);
      cmd_out <= (settle_r > 0) ? {1'b0, cmd_in[2:0]} : cmd_in;
   end
   // The flag means nothing while asleep, so it is disregarded there.
   assign flag_seen_out = standby_n_out & flag_oe_in;
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the full-bridge control and fault logic.
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam DEAD = 4;
   localparam RETRY = 20;
   logic clk = 0, rst = 1, wake = 1, psel = 0, pen = 0, pwr = 0, z;
   logic sh = 0, st = 0, nz = 0, lo = 0, bel = 1, pump = 0, warn = 0, cut = 0;
   logic [3:0] cmd = 0;
   logic [7:0] pa = 0;
   logic [31:0] pw = 0;
   logic [32:0] rres, rq[$];
   logic [9:0] pv, pq[$];
   int num_errors = 0, checks = 0, cyc = 0, i;
   wire stby, seen, prdy, perr, ph, pl, nh, nl, oe, fn;
   wire [3:0] pins;
   wire [31:0] prd;
   wire [4:0] obs = {seen, ph, pl, nh, nl};
   event ev_rd, ev_pin;
   `define CK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
      $display("CHECK FAILED at %0t got %h exp %h", $time, g, e); end end
   always #2.5 clk = ~clk;
   hbcfl_host_model hbcfl_host_model_i (.clk_in(clk), .wake_in(wake), .cmd_in(cmd), .flag_oe_in(oe),
      .standby_n_out(stby), .cmd_out(pins), .flag_seen_out(seen));
   hbcfl_top #(.RETRY_CYCLES(RETRY), .DEAD_CYCLES(DEAD)) hbcfl_top_i (.SYS_CLK_IN(clk), .RST_IN(rst),
      .STANDBY_REQUEST_N_IN(stby), .ENABLE_IN(pins[3]), .DIRECTION_SELECT_IN(pins[2]), .DECAY_SELECT_IN(pins[1]),
      .RECIRC_SIDE_SELECT_IN(pins[0]), .SHORT_DETECT_IN(sh), .SHUNT_TRIP_IN(st), .CURRENT_NEAR_ZERO_IN(nz),
      .SUPPLY_LOCKOUT_IN(lo), .SUPPLY_BELOW_RELEASE_IN(bel), .PUMP_RAIL_LOW_IN(pump), .THERMAL_WARN_IN(warn),
      .THERMAL_CUTOFF_IN(cut), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pw),
      .PREADY_OUT(prdy), .PRDATA_OUT(prd), .PSLVERR_OUT(perr), .POS_HIGH_ON_OUT(ph), .POS_LOW_ON_OUT(pl),
      .NEG_HIGH_ON_OUT(nh), .NEG_LOW_ON_OUT(nl), .RAILS_ENABLE_OUT(), .PROBLEM_FLAG_N_OUT(fn),
      .PROBLEM_FLAG_OE_OUT(oe));
   // Each result that appears is paired with the oldest note of its kind.
   always @(ev_rd) `CK(rres, rq.pop_front())
   always @(ev_pin)
   begin
      pv = pq.pop_front();
      `CK(obs & pv[9:5], pv[4:0])
   end
   // A hang is cut short well beyond the expected run length.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         num_errors++;
         close_out;
      end
   end
   task close_out;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task apb(input bit w, input [7:0] a, input [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwr <= w;
      pa <= a;
      pw <= d;
      @(posedge clk);
      pen <= 1;
      do @(posedge clk); while (prdy !== 1'b1);
      rres = {perr, prd};
      psel <= 0;
      pen <= 0;
   endtask
   task rd(input [7:0] a, input [32:0] e);
      apb(0, a, 0);
      rq.push_back(e);
      ->ev_rd;
   endtask
   // Legs pass one edge in the host, one in the block, then the dead time.
   task pin(input [4:0] e, input [4:0] m);
      repeat (DEAD + 4) @(posedge clk);
      #1;
      pq.push_back({m, e & m});
      ->ev_pin;
      // Hand back on a rising edge so the caller's next stimulus lands on the clock.
      @(posedge clk);
   endtask
   function automatic [3:0] legs(input [3:0] c, input bit zc);
      if (c[3]) return c[2] ? 4'h9 : 4'h6;
      if (c[1]) return c[0] ? 4'hA : 4'h5;
      return zc ? 4'h0 : (c[2] ? 4'h6 : 4'h9);
   endfunction
   // Main sequence of scenarios.
   initial
   begin
      i = $urandom(32'h140fb945);
      repeat (20) @(posedge clk);
      rst <= 0;
      repeat (40) @(posedge clk);
      cmd <= 4'hC;
      pin(5'h19, 5'h1F);
      bel <= 0;
      pin(5'h09, 5'h1F);
      $display("undervoltage hold done");
      for (i = 0; i < 16; i++)
      begin
         z = $urandom % 2;
         cmd <= i[3:0];
         nz <= z;
         pin({1'b0, legs(i[3:0], z)}, 5'h1F);
      end
      nz <= 0;
      cmd <= 4'hC;
      warn <= 1;
      pin(5'h19, 5'h1F);
      warn <= 0;
      cmd <= 4'hE;
      st <= 1;
      pin(5'h05, 5'h0F);
      st <= 0;
      cmd <= 4'hC;
      for (i = 0; i < 3; i++)
      begin
         {cut, pump, lo} <= 3'h1 << i;
         pin(5'h00, 5'h0F);
         {cut, pump, lo} <= 3'h0;
         pin(5'h09, 5'h0F);
      end
      $display("modes and protection done");
      sh <= 1;
      pin(5'h10, 5'h1F);
      sh <= 0;
      repeat (RETRY) @(posedge clk);
      pin(5'h09, 5'h1F);
      rd(8'h08, 33'h1);
      apb(1, 8'h08, 32'h0);
      rd(8'h08, 33'h0);
      apb(1, 8'h00, 32'h0000001F);
      rd(8'h00, 33'h1F);
      apb(1, 8'h00, 32'h0);
      rd(8'h04, 33'h982);
      rd(8'h0C, 33'h100000000);
      $display("short retry and registers done");
      wake <= 0;
      pin(5'h00, 5'h0F);
      wake <= 1;
      repeat (40) @(posedge clk);
      pin(5'h09, 5'h1F);
      $display("sleep done");
      `CK(fn, 1'b0)
      close_out;
   end
endmodule
bind hbcfl_top hbcfl_monitor #(.RETRY_CYCLES(RETRY_CYCLES), .DEAD_CYCLES(DEAD_CYCLES)) hbcfl_monitor_i (
   .SYS_CLK_IN, .RST_IN, .STANDBY_REQUEST_N_IN, .SHORT_DETECT_IN, .THERMAL_WARN_IN, .THERMAL_CUTOFF_IN,
   .PUMP_RAIL_LOW_IN, .SUPPLY_LOCKOUT_IN, .POS_HIGH_ON_OUT, .POS_LOW_ON_OUT, .NEG_HIGH_ON_OUT,
   .NEG_LOW_ON_OUT, .RAILS_ENABLE_OUT, .PROBLEM_FLAG_OE_OUT);
